// file: logic/ocs_pkg.sv
package ocs_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 40;
   localparam int MS_TIME_NS      = 1000000;
   localparam int CYC_PER_MS      = (MS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BLOCK_MARGIN_MS = 5;
   localparam int PRE_TRIG_MS     = 20;
   localparam int PRE_FAULT_MS    = 200;
   localparam int MAX_OP_TIME_S   = 1800;
   localparam int MAX_OP_MS       = MAX_OP_TIME_S * 1000;

   // ----------------------------------------------------------------
   // Widths and depths
   // ----------------------------------------------------------------
   localparam int CUR_W      = 16;
   localparam int MS_W       = 21;
   localparam int TS_W       = 32;
   localparam int PCT_W      = 14;
   localparam int CNT_W      = 16;
   localparam int ACC_W      = 32;
   localparam int REC_DEPTH  = 12;
   localparam int NUM_STAGES = 3;
   localparam int NUM_EV     = 9;

   // ----------------------------------------------------------------
   // Event indices (status vector bit positions)
   // ----------------------------------------------------------------
   localparam int EV_START   = 0;
   localparam int EV_TRIP    = 1;
   localparam int EV_BLOCK   = 2;
   localparam int EV_START_A = 3;
   localparam int EV_TRIP_A  = 6;

   // ----------------------------------------------------------------
   // Record kinds
   // ----------------------------------------------------------------
   localparam logic [1:0] REC_START = 2'h0;
   localparam logic [1:0] REC_TRIP  = 2'h1;
   localparam logic [1:0] REC_BLOCK = 2'h2;

   typedef enum logic [2:0] {
      OCS_IDLE    = 3'b000,
      OCS_START   = 3'b001,
      OCS_TRIP    = 3'b010,
      OCS_BLOCKED = 3'b011,
      OCS_RELEASE = 3'b100
   } ocs_state_t;

   typedef struct packed {
      logic             trip_idmt;
      logic             reset_idmt;
      logic [MS_W-1:0]  trip_ms;
      logic [MS_W-1:0]  reset_ms;
      logic [ACC_W-1:0] idmt_k;
      logic [CUR_W-1:0] reset_step;
      logic             harm_en;
      logic [PCT_W-1:0] harm_limit;
      logic [CUR_W-1:0] i_set;
      logic [2:0]       group;
   } ocs_cfg_t;

   localparam ocs_cfg_t CFG_RST = '{
      trip_idmt:  1'b0,
      reset_idmt: 1'b0,
      trip_ms:    21'h0003e8,
      reset_ms:   21'h000000,
      idmt_k:     32'h000186a0,
      reset_step: 16'h0064,
      harm_en:    1'b0,
      harm_limit: 14'h0001,
      i_set:      16'h0078,
      group:      3'h0
   };

   typedef struct packed {
      logic [1:0]      stage;
      logic [3:0]      index;
      logic            falling;
      logic [TS_W-1:0] ts;
   } ocs_evt_t;

   typedef struct packed {
      logic [TS_W-1:0]  ts;
      logic [1:0]       kind;
      logic [2:0]       phases;
      logic [CUR_W-1:0] pre_trig;
      logic [CUR_W-1:0] fault_cur;
      logic [CUR_W-1:0] pre_fault;
      logic [MS_W-1:0]  remain;
      logic [2:0]       group;
   } ocs_rec_t;

endpackage : ocs_pkg

// file: logic/ocs_counter.sv
`timescale 1ns/100ps
module ocs_counter #(
   parameter int WIDTH = 16
) (
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             resetn,
   // Control
   input  wire logic             inc,
   input  wire logic             clr,
   // Count
   output logic      [WIDTH-1:0] count
);

   initial begin
      if (WIDTH < 2) $error("ocs_counter: WIDTH too small");
   end

   // A simultaneous clear and increment leave a count of one
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         count <= '0;
      end else if (inc) begin
         count <= clr ? {{(WIDTH-1){1'b0}}, 1'b1} : count + 1'b1;
      end else if (clr) begin
         count <= '0;
      end
   end

endmodule : ocs_counter

// file: logic/ocs_stage.sv
`timescale 1ns/100ps
module ocs_stage #(
   parameter int STAGE_ID   = 0,
   parameter int CYC_PER_MS = ocs_pkg::CYC_PER_MS,
   parameter int REC_DEPTH  = ocs_pkg::REC_DEPTH
) (
   // Clock and reset
   input  wire logic                                  clock,
   input  wire logic                                  resetn,
   // Configuration
   input  wire logic                                  cfg_load,
   input  wire ocs_pkg::ocs_cfg_t                     cfg_in,
   input  wire logic [ocs_pkg::NUM_EV-1:0]            ev_on_mask,
   input  wire logic [ocs_pkg::NUM_EV-1:0]            ev_off_mask,
   // Measurement and blocking
   input  wire logic                                  block_in,
   input  wire logic [2:0]                            pickup_abc,
   input  wire logic [ocs_pkg::CUR_W-1:0]             i_meas,
   input  wire logic [ocs_pkg::PCT_W-1:0]             harm2_pct,
   // Status
   output logic                                       start_act,
   output logic                                       trip_act,
   output logic                                       blocked_act,
   output logic      [2:0]                            start_abc,
   output logic      [2:0]                            trip_abc,
   output logic      [ocs_pkg::MS_W-1:0]              remain_ms,
   output logic                                       cycle_tick,
   // Events
   output logic                                       evt_valid,
   output ocs_pkg::ocs_evt_t                          evt,
   // Counters
   input  wire logic [2:0]                            cnt_clear,
   output logic      [ocs_pkg::CNT_W-1:0]             cnt_start,
   output logic      [ocs_pkg::CNT_W-1:0]             cnt_trip,
   output logic      [ocs_pkg::CNT_W-1:0]             cnt_block,
   // Fault records
   input  wire logic [3:0]                            rec_sel,
   output ocs_pkg::ocs_rec_t                          rec_data,
   output logic      [3:0]                            rec_used
);
   import ocs_pkg::*;

   localparam int HIST   = PRE_FAULT_MS;
   localparam int HP_W   = $clog2(HIST);
   localparam int DIV_W  = $clog2(CYC_PER_MS + 1);
   localparam int RP_W   = 4;
   localparam int PEND_W = 2 * NUM_EV;

   initial begin
      if (STAGE_ID < 0 || STAGE_ID >= NUM_STAGES) $error("ocs_stage: bad STAGE_ID");
      if (CYC_PER_MS < 1) $error("ocs_stage: CYC_PER_MS must be at least 1");
      if (REC_DEPTH < 1 || REC_DEPTH > 16) $error("ocs_stage: REC_DEPTH out of range");
   end

   // ----------------------------------------------------------------
   // Program cycle divider and millisecond timestamp
   // ----------------------------------------------------------------
   logic [DIV_W-1:0] div_q;
   logic [TS_W-1:0]  ts_q;
   logic             tick;

   assign tick       = (div_q == DIV_W'(CYC_PER_MS - 1));
   assign cycle_tick = tick;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         div_q <= '0;
      end else begin
         div_q <= tick ? '0 : div_q + 1'b1;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ts_q <= '0;
      end else if (tick) begin
         ts_q <= ts_q + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Configuration held locally so defaults hold after reset
   // ----------------------------------------------------------------
   ocs_cfg_t cfg_q;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cfg_q <= CFG_RST;
      end else if (cfg_load) begin
         cfg_q <= cfg_in;
      end
   end

   // ----------------------------------------------------------------
   // Current history for pre-trigger and pre-fault values
   // ----------------------------------------------------------------
   logic [CUR_W-1:0] hist [0:HIST-1];
   logic [HP_W-1:0]  hp_q;
   logic [CUR_W-1:0] cur_m20;
   logic [CUR_W-1:0] cur_m200;

   assign cur_m200 = hist[hp_q];
   assign cur_m20  = hist[HP_W'((int'(hp_q) + HIST - PRE_TRIG_MS) % HIST)];

   // History is not reset; early records may carry stale samples
   always_ff @(posedge clock) begin
      if (tick) begin
         hist[hp_q] <= i_meas;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         hp_q <= '0;
      end else if (tick) begin
         hp_q <= (hp_q == HP_W'(HIST - 1)) ? '0 : hp_q + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Stage state machine
   // ----------------------------------------------------------------
   ocs_state_t       state_q, state_d;
   logic [MS_W-1:0]  elapsed_q, elapsed_d;
   logic [MS_W-1:0]  rel_q, rel_d;
   logic [ACC_W-1:0] acc_q, acc_d;
   logic [ACC_W-1:0] excess;
   logic             blk;
   logic             pick;

   // Block is looked at only on the cycle tick, so it is one sample per cycle
   assign blk  = block_in | (cfg_q.harm_en && harm2_pct >= cfg_q.harm_limit);
   assign pick = |pickup_abc;
   // Inverse time integrates the excess over setting; time ~ k / (I - Iset)
   assign excess = (i_meas > cfg_q.i_set) ? ACC_W'(i_meas - cfg_q.i_set) : ACC_W'(1);

   always_comb begin
      state_d   = state_q;
      elapsed_d = elapsed_q;
      rel_d     = rel_q;
      acc_d     = acc_q;
      if (tick) begin
         case (state_q)
            OCS_IDLE: begin
               if (pick && blk) begin
                  state_d = OCS_BLOCKED;
               end else if (pick) begin
                  state_d   = OCS_START;
                  elapsed_d = '0;
                  acc_d     = '0;
                  rel_d     = '0;
               end
            end
            OCS_BLOCKED: begin
               if (!blk || !pick) begin
                  state_d = OCS_IDLE;
               end
            end
            OCS_START: begin
               if (blk || !pick) begin
                  state_d = OCS_RELEASE;
                  rel_d   = '0;
               end else begin
                  if (elapsed_q < MS_W'(MAX_OP_MS)) begin
                     elapsed_d = elapsed_q + 1'b1;
                  end
                  acc_d = acc_q + excess;
                  if (cfg_q.trip_idmt ? (acc_d >= cfg_q.idmt_k)
                                      : (elapsed_d >= cfg_q.trip_ms)) begin
                     state_d = OCS_TRIP;
                  end
               end
            end
            OCS_TRIP: begin
               if (blk || !pick) begin
                  state_d = OCS_RELEASE;
                  rel_d   = '0;
               end
            end
            OCS_RELEASE: begin
               if (pick && !blk) begin
                  state_d = OCS_START;
               end else if (cfg_q.reset_idmt) begin
                  acc_d = (acc_q > ACC_W'(cfg_q.reset_step)) ?
                          acc_q - ACC_W'(cfg_q.reset_step) : '0;
                  if (acc_d == '0) begin
                     state_d = OCS_IDLE;
                  end
               end else begin
                  rel_d = rel_q + 1'b1;
                  if (rel_d >= cfg_q.reset_ms) begin
                     state_d = OCS_IDLE;
                  end
               end
            end
            default: state_d = OCS_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_q   <= OCS_IDLE;
         elapsed_q <= '0;
         rel_q     <= '0;
         acc_q     <= '0;
      end else begin
         state_q   <= state_d;
         elapsed_q <= elapsed_d;
         rel_q     <= rel_d;
         acc_q     <= acc_d;
      end
   end

   // ----------------------------------------------------------------
   // Status outputs
   // ----------------------------------------------------------------
   logic              start_d, trip_d, blocked_d;
   logic [MS_W-1:0]   remain_d;
   logic [NUM_EV-1:0] st_d, st_q, rise, fall;

   assign start_d   = (state_d == OCS_START) || (state_d == OCS_TRIP);
   assign trip_d    = (state_d == OCS_TRIP);
   assign blocked_d = (state_d == OCS_BLOCKED);
   assign remain_d  = (state_d != OCS_START || cfg_q.trip_idmt) ? '0 :
                      (cfg_q.trip_ms > elapsed_d) ? cfg_q.trip_ms - elapsed_d : '0;
   assign st_d = {trip_d ? pickup_abc : 3'h0, start_d ? pickup_abc : 3'h0,
                  blocked_d, trip_d, start_d};
   assign st_q = {trip_abc, start_abc, blocked_act, trip_act, start_act};
   assign rise = tick ? (st_d & ~st_q) : '0;
   assign fall = tick ? (~st_d & st_q) : '0;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         start_act   <= 1'b0;
         trip_act    <= 1'b0;
         blocked_act <= 1'b0;
         start_abc   <= 3'h0;
         trip_abc    <= 3'h0;
         remain_ms   <= '0;
      end else if (tick) begin
         start_act   <= start_d;
         trip_act    <= trip_d;
         blocked_act <= blocked_d;
         start_abc   <= st_d[EV_START_A +: 3];
         trip_abc    <= st_d[EV_TRIP_A +: 3];
         remain_ms   <= remain_d;
      end
   end

   // ----------------------------------------------------------------
   // Event emission, one per clock from the pending set
   // ----------------------------------------------------------------
   logic [PEND_W-1:0] pend_q, pend_new, pend_clr;
   logic [TS_W-1:0]   evt_ts_q;
   logic [4:0]        sel;
   logic              any;

   assign pend_new = {fall & ev_off_mask, rise & ev_on_mask};

   always_comb begin
      sel = '0;
      any = 1'b0;
      for (int i = PEND_W - 1; i >= 0; i--) begin
         if (pend_q[i]) begin
            sel = 5'(i);
            any = 1'b1;
         end
      end
      pend_clr = any ? (PEND_W'(1) << sel) : '0;
   end

   // A new event wins over the clear of the one leaving
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pend_q <= '0;
      end else begin
         pend_q <= (pend_q & ~pend_clr) | pend_new;
      end
   end

   // Program cycle far exceeds the drain time, so one stamp per cycle suffices
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         evt_ts_q <= '0;
      end else if (|pend_new) begin
         evt_ts_q <= ts_q;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         evt_valid <= 1'b0;
         evt       <= '0;
      end else begin
         evt_valid <= any;
         if (any) begin
            evt.stage   <= 2'(STAGE_ID);
            evt.index   <= 4'(sel % NUM_EV);
            evt.falling <= (sel >= 5'(NUM_EV));
            evt.ts      <= evt_ts_q;
         end
      end
   end

   // ----------------------------------------------------------------
   // Cumulative counters
   // ----------------------------------------------------------------
   ocs_counter #(.WIDTH(CNT_W)) u_cnt_start (
      .clock(clock), .resetn(resetn), .inc(rise[EV_START]), .clr(cnt_clear[0]),
      .count(cnt_start));
   ocs_counter #(.WIDTH(CNT_W)) u_cnt_trip (
      .clock(clock), .resetn(resetn), .inc(rise[EV_TRIP]), .clr(cnt_clear[1]),
      .count(cnt_trip));
   ocs_counter #(.WIDTH(CNT_W)) u_cnt_block (
      .clock(clock), .resetn(resetn), .inc(rise[EV_BLOCK]), .clr(cnt_clear[2]),
      .count(cnt_block));

   // ----------------------------------------------------------------
   // Fault record store
   // ----------------------------------------------------------------
   ocs_rec_t        rec_mem [0:REC_DEPTH-1];
   ocs_rec_t        rec_new;
   logic [RP_W-1:0] wp_q, rd_idx;
   logic [CUR_W-1:0] pre_fault_q;
   logic            rec_cap;

   assign rec_cap = rise[EV_START] | rise[EV_TRIP] | rise[EV_BLOCK];
   assign rd_idx  = RP_W'((int'(wp_q) + 2 * REC_DEPTH - 1 - int'(rec_sel)) % REC_DEPTH);

   // One record per cycle; trip outranks start, start outranks blocked
   always_comb begin
      rec_new           = '0;
      rec_new.ts        = ts_q;
      rec_new.kind      = rise[EV_TRIP] ? REC_TRIP : rise[EV_START] ? REC_START : REC_BLOCK;
      rec_new.phases    = pickup_abc;
      rec_new.pre_trig  = cur_m20;
      rec_new.fault_cur = i_meas;
      rec_new.pre_fault = rise[EV_TRIP] ? pre_fault_q : cur_m200;
      rec_new.remain    = remain_d;
      rec_new.group     = cfg_q.group;
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pre_fault_q <= '0;
      end else if (rise[EV_START]) begin
         pre_fault_q <= cur_m200;
      end
   end

   always_ff @(posedge clock) begin
      if (rec_cap) begin
         rec_mem[wp_q] <= rec_new;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         wp_q     <= '0;
         rec_used <= '0;
      end else if (rec_cap) begin
         wp_q <= (wp_q == RP_W'(REC_DEPTH - 1)) ? '0 : wp_q + 1'b1;
         if (rec_used != 4'(REC_DEPTH)) begin
            rec_used <= rec_used + 1'b1;
         end
      end
   end

   // Selector 0 is the newest record; unused slots read as zero
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rec_data <= '0;
      end else if (rec_sel < rec_used) begin
         rec_data <= rec_mem[rd_idx];
      end else begin
         rec_data <= '0;
      end
   end

endmodule : ocs_stage

// file: dv/ocs_stage_monitor.sv
`timescale 1ns/100ps
module ocs_stage_monitor #(
   parameter int STAGE_ID = 0
) (
   // Clock and reset
   input wire logic                        clock,
   input wire logic                        resetn,
   // Stimulus seen
   input wire logic                        block_in,
   input wire logic [2:0]                  pickup_abc,
   input wire logic [ocs_pkg::PCT_W-1:0]   harm2_pct,
   input wire logic [ocs_pkg::NUM_EV-1:0]  ev_on_mask,
   input wire logic [2:0]                  cnt_clear,
   // Status seen
   input wire logic                        start_act,
   input wire logic                        trip_act,
   input wire logic                        blocked_act,
   input wire logic [2:0]                  start_abc,
   input wire logic [2:0]                  trip_abc,
   input wire logic                        cycle_tick,
   input wire logic                        evt_valid,
   input wire ocs_pkg::ocs_evt_t           evt,
   input wire logic [ocs_pkg::CNT_W-1:0]   cnt_trip,
   input wire logic [3:0]                  rec_used
);
   import ocs_pkg::*;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);

   AST_TICK_ONLY: assert property (
      $changed({start_act, trip_act, blocked_act}) |-> $past(cycle_tick))
      else $error("status moved between ticks");
   AST_START_FREE: assert property (
      cycle_tick && (|pickup_abc) && !block_in && harm2_pct == '0 && !blocked_act
      |=> start_act)
      else $error("pickup without block gave no start");
   AST_BLOCK_STOP: assert property (
      cycle_tick && block_in |=> !start_act && !trip_act)
      else $error("start or trip under block");
   AST_BLOCK_DROP: assert property (
      cycle_tick && blocked_act && !block_in && harm2_pct == '0 |=> !blocked_act)
      else $error("blocked held after block left");
   AST_TRIP_AFTER: assert property (
      $rose(trip_act) |-> $past(start_act))
      else $error("trip without prior start");
   AST_PHASE_MAP: assert property (
      cycle_tick |=> start_abc == (start_act ? $past(pickup_abc) : 3'h0)
                     && trip_abc == (trip_act ? $past(pickup_abc) : 3'h0))
      else $error("phase outputs wrong");
   AST_EVT_START: assert property (
      $rose(start_act) && ev_on_mask[0] |-> ##[0:2] evt_valid)
      else $error("start event missing");
   AST_EVT_STAGE: assert property (
      evt_valid |-> evt.stage == 2'(STAGE_ID))
      else $error("event stage wrong");
   AST_CNT_CLEAR: assert property (
      cnt_clear[1] |=> cnt_trip <= 16'h0001)
      else $error("trip counter not cleared");
   AST_REC_STEP: assert property (
      $changed(rec_used) |-> rec_used == $past(rec_used) + 4'h1 && rec_used <= 4'hc)
      else $error("record count step wrong");
endmodule : ocs_stage_monitor

bind ocs_stage ocs_stage_monitor #(.STAGE_ID(STAGE_ID)) u_mon (
   .clock(clock), .resetn(resetn), .block_in(block_in), .pickup_abc(pickup_abc),
   .harm2_pct(harm2_pct), .ev_on_mask(ev_on_mask), .cnt_clear(cnt_clear),
   .start_act(start_act), .trip_act(trip_act), .blocked_act(blocked_act),
   .start_abc(start_abc), .trip_abc(trip_abc), .cycle_tick(cycle_tick),
   .evt_valid(evt_valid), .evt(evt), .cnt_trip(cnt_trip), .rec_used(rec_used));

// file: dv/ocs_far_model.sv
`timescale 1ns/100ps
module ocs_far_model (
   // Clock
   input  wire logic              clock,
   // Blocking matrix
   input  wire logic              blk_req,
   output logic                   block_in,
   // Event buffer
   input  wire logic              evt_valid,
   input  wire ocs_pkg::ocs_evt_t evt
);
   import ocs_pkg::*;
   ocs_evt_t evt_log [0:63];
   int       evt_cnt = 0;

   initial block_in = 1'b0;
   // Registered, so the block lands one clock after the request
   always @(posedge clock) block_in <= #1 blk_req;
   // Buffer takes every event shown, no back-pressure
   always @(posedge clock) begin
      if (evt_valid === 1'b1) begin
         evt_log[evt_cnt[5:0]] <= evt;
         evt_cnt <= evt_cnt + 1;
      end
   end
endmodule : ocs_far_model

// file: dv/ocs_stage_bench.sv
`timescale 1ns/100ps
module ocs_stage_bench;
   import ocs_pkg::*;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   localparam int CPM = 4; // Short program cycle keeps the run brief
   logic              clock;
   logic              resetn;
   logic              cfg_load;
   ocs_cfg_t          cfg_in;
   ocs_cfg_t          c;
   logic [NUM_EV-1:0] ev_on_mask;
   logic [NUM_EV-1:0] ev_off_mask;
   logic              blk_req;
   logic              block_in;
   logic [2:0]        pickup_abc;
   logic [CUR_W-1:0]  i_meas;
   logic [PCT_W-1:0]  harm2_pct;
   logic              start_act;
   logic              trip_act;
   logic              blocked_act;
   logic [2:0]        start_abc;
   logic [2:0]        trip_abc;
   logic [MS_W-1:0]   remain_ms;
   logic              cycle_tick;
   logic              evt_valid;
   ocs_evt_t          evt;
   logic [2:0]        cnt_clear;
   logic [CNT_W-1:0]  cnt_start;
   logic [CNT_W-1:0]  cnt_trip;
   logic [CNT_W-1:0]  cnt_block;
   logic [3:0]        rec_sel;
   ocs_rec_t          rec_data;
   logic [3:0]        rec_used;
   int                num_errors = 0;
   int                checks = 0;
   int                n;
   int                exp_idx [6] = '{0, 3, 5, 1, 6, 8};

   ocs_stage #(.STAGE_ID(0), .CYC_PER_MS(CPM), .REC_DEPTH(12)) uut (
      .clock(clock), .resetn(resetn), .cfg_load(cfg_load), .cfg_in(cfg_in),
      .ev_on_mask(ev_on_mask), .ev_off_mask(ev_off_mask), .block_in(block_in),
      .pickup_abc(pickup_abc), .i_meas(i_meas), .harm2_pct(harm2_pct),
      .start_act(start_act), .trip_act(trip_act), .blocked_act(blocked_act),
      .start_abc(start_abc), .trip_abc(trip_abc), .remain_ms(remain_ms), .cycle_tick(cycle_tick),
      .evt_valid(evt_valid), .evt(evt), .cnt_clear(cnt_clear), .cnt_start(cnt_start),
      .cnt_trip(cnt_trip), .cnt_block(cnt_block), .rec_sel(rec_sel),
      .rec_data(rec_data), .rec_used(rec_used));

   ocs_far_model far (.clock(clock), .blk_req(blk_req), .block_in(block_in),
      .evt_valid(evt_valid), .evt(evt));

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t %s", $time, what);
      end
   endtask : chk

   task automatic test_done();
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : test_done

   // Bounded wait for the next program cycle edge
   // Tick looked at mid-cycle, clear of the edge that moves it
   task automatic tick();
      int i;
      for (i = 0; i < 3 * CPM; i++) begin
         @(negedge clock);
         if (cycle_tick === 1'b1) break;
      end
      if (i == 3 * CPM) begin
         num_errors++;
         $display("ERROR %0t no program tick", $time);
         test_done();
      end
      @(posedge clock);
      #1;
   endtask : tick

   task automatic load(input ocs_cfg_t v);
      cfg_in = v;
      cfg_load = 1'b1;
      @(posedge clock);
      #1 cfg_load = 1'b0;
   endtask : load

   task automatic read_rec(input logic [3:0] sel);
      rec_sel = sel;
      @(posedge clock);
      #1;
   endtask : read_rec

   // ----------------------------------------------------------------
   // Stimulus
   // ----------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   initial begin
      resetn = 1'b0;
      cfg_load = 1'b0;
      cfg_in = CFG_RST;
      ev_on_mask = 9'h1ff;
      ev_off_mask = 9'h1ff;
      blk_req = 1'b0;
      pickup_abc = 3'h0;
      i_meas = 16'h0100;
      harm2_pct = 14'h0000;
      cnt_clear = 3'h0;
      rec_sel = 4'h0;
      repeat (5) @(posedge clock);
      #1 resetn = 1'b1;
      chk(start_act, 1'b0, "start after reset");
      chk(rec_used, 4'h0, "records after reset");
      // Definite time trip, three ticks
      c = CFG_RST;
      c.trip_ms = 21'h000003;
      c.group = 3'h2;
      load(c);
      tick();
      pickup_abc = 3'b101;
      tick();
      chk({start_act, start_abc, trip_act}, 5'b1_101_0, "start on pickup");
      tick();
      tick();
      chk(trip_act, 1'b0, "trip too early");
      chk(remain_ms, 21'h000001, "remaining time");
      tick();
      chk({trip_act, trip_abc}, 4'b1_101, "trip at delay");
      blk_req = 1'b1;
      read_rec(4'h0);
      chk({rec_data.kind, rec_data.group, rec_data.phases}, {REC_TRIP, 6'o25}, "trip rec");
      chk(rec_data.fault_cur, 16'h0100, "record current");
      read_rec(4'h1);
      chk(rec_data.kind, REC_START, "start record");
      chk({rec_data.remain, rec_data.ts}, {21'h000003, 32'h00000001}, "start rec fields");
      $display("test dt_trip done");
      // Late block drops start, then blocked
      tick();
      chk({start_act, trip_act}, 2'b00, "late block");
      for (int k = 0; k < 6; k++) begin
         chk(far.evt_log[k].index, exp_idx[k], "event order");
      end
      chk(far.evt_log[3].ts - far.evt_log[0].ts, 32'h3, "event time gap");
      tick();
      tick();
      chk({blocked_act, start_act}, 2'b10, "blocked on pickup");
      blk_req = 1'b0;
      tick();
      chk({blocked_act, start_act}, 2'b00, "blocked release");
      tick();
      chk(start_act, 1'b1, "resume after block");
      $display("test block done");
      // Harmonic block at its limit, falling-only mask
      pickup_abc = 3'h0;
      tick();
      tick();
      ev_on_mask = 9'h000;
      ev_off_mask = 9'h004;
      n = far.evt_cnt;
      harm2_pct = 14'h03e8;
      pickup_abc = 3'b010;
      c.harm_en = 1'b1;
      c.harm_limit = 14'h03e8;
      load(c);
      tick();
      chk({blocked_act, start_act}, 2'b10, "harmonic block");
      harm2_pct = 14'h03e7;
      tick();
      chk(blocked_act, 1'b0, "harmonic under limit");
      tick();
      chk(start_act, 1'b1, "start under limit");
      repeat (3) @(posedge clock);
      #1;
      chk(far.evt_cnt - n, 1, "masked event count");
      chk({far.evt_log[n].index, far.evt_log[n].falling}, 5'h05, "falling only");
      chk({cnt_start, cnt_trip, cnt_block}, 48'h0003_0001_0002, "counters");
      cnt_clear = 3'h7;
      @(posedge clock);
      #1 cnt_clear = 3'h0;
      chk({cnt_start, cnt_trip, cnt_block}, 48'h0, "counters cleared");
      $display("test harmonic done");
      // Roll the record store past twelve
      for (int k = 0; k < 7; k++) begin
         pickup_abc = 3'h0;
         tick();
         tick();
         pickup_abc = 3'b001;
         tick();
      end
      chk(rec_used, 4'hc, "store full");
      read_rec(4'hb);
      chk(rec_data.kind, REC_TRIP, "oldest kept");
      read_rec(4'hc);
      chk(rec_data, '0, "beyond store");
      $display("test records done");
      test_done();
   end
endmodule : ocs_stage_bench
